/* shared/esu_defs.svh */
// register offsets, bit positions, reset values and timing counts of the serial interrupt/data block
`ifndef ESU_DEFS_SVH
`define ESU_DEFS_SVH
`define ESU_ADDR_DATA      8'hA6
`define ESU_ADDR_IRQ       8'hA7
`define ESU_RST_IRQ        8'h00
`define ESU_RST_DATA       8'h00
`define ESU_BIT_MASTER     7
`define ESU_BIT_TXSPACE    6
`define ESU_BIT_RXAVAIL    5
`define ESU_BIT_RXOVF      4
`define ESU_BIT_RXUDF      3
`define ESU_BIT_TXOVF      2
`define ESU_BIT_FRAME_ERROR_FLAG       1
`define ESU_BIT_TXDONE     0
`define ESU_IDLE_MULT      16
`define ESU_SYNC_BYTE      8'h55
`endif

/* shared/esu_pkg.sv */
// types shared by the serial interrupt/data block
package esu_pkg;
	typedef enum logic [2:0] {
		ESU_HDR_IDLE  = 3'b000,
		ESU_HDR_BREAK = 3'b001,
		ESU_HDR_SYNC  = 3'b010,
		ESU_HDR_ID    = 3'b011,
		ESU_HDR_DATA  = 3'b100
	} esu_hdr_t;
endpackage

/* rtl/esu_fifo.sv */
// small synchronous fifo with valid/ready on both sides and registered read data
`timescale 1ns/1ps
module esu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int LW    = $clog2(DEPTH + 1)
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	// occupancy
	output logic      [LW-1:0]    level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [LW-1:0]    cnt_q;
	logic             push;
	logic             pop;
	logic [AW-1:0]    rp_n;

	assign in_ready  = (cnt_q != LW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign level     = cnt_q;
	assign rp_n      = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;

	// storage, written only when there is room
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// pointers and count; flush empties the queue
	always_ff @(posedge clk) begin
		if (rst || flush) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_n;
			end
			cnt_q <= cnt_q + LW'(push) - LW'(pop);
		end
	end

	// head word kept in a register; look ahead on pop so it is fresh next cycle
	always_ff @(posedge clk) begin
		if (rst || flush) begin
			out_data <= '0;
		end else if (push && (cnt_q == '0 || (pop && cnt_q == LW'(1)))) begin
			out_data <= in_data;
		end else if (pop) begin
			out_data <= mem_q[rp_n];
		end else if (cnt_q != '0) begin
			out_data <= mem_q[rp_q];
		end
	end
endmodule

/* rtl/esu_core.sv */
// interrupt status/enable, shared data port and lin master header sequencing of the serial unit
// Function
// - raise transmit-space flag while transmit queue level is below its threshold.
// - transmit-space flag clears itself once the queue is no longer below threshold.
// - writing one to a bit of the interrupt register enables that source.
// - receive-available also sets when level below threshold and idle exceeds threshold*16 bauds.
// - transmit-done stays set until zero written; that write disables its interrupt.
// - reading the data port returns and removes the oldest received byte.
// - writing the data port appends the byte to the transmit queue.
// - lin mode leaves every ordinary serial register and function working.
// - lin supports master and slave roles and baud sync to sync field; this block only tracks the master header, with no slave role or baud sync.
// - a lin message goes break, sync, identifier, data, checksum; the tracker has no checksum state and counts checksum bytes as data.
// - each lin frame lasts a fixed time matching its bit count; no frame timer here, the header ends when transmit goes idle.
// - queue reset by disabling the port clears overflow and underflow flags.
`timescale 1ns/1ps
`include "esu_defs.svh"
module esu_core
	import esu_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int LW    = 4
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// special-function bus
	input  wire logic [7:0]    sfr_addr,
	input  wire logic          sfr_wr,
	input  wire logic          sfr_rd,
	input  wire logic [7:0]    sfr_wdata,
	output logic      [7:0]    sfr_rdata,
	// configuration from the neighbouring line-format and fifo registers
	input  wire logic          port_disable,
	input  wire logic [LW-1:0] rx_threshold,
	input  wire logic [LW-1:0] tx_threshold,
	input  wire logic          lin_enable,
	input  wire logic          lin_master,
	input  wire logic          break_request,
	// serial engine side: transmit drain
	output logic               tx_valid,
	input  wire logic          tx_ready,
	output logic      [7:0]    tx_data,
	input  wire logic          tx_shift_idle,
	// serial engine side: receive fill
	input  wire logic          rx_valid,
	output logic               rx_ready,
	input  wire logic [7:0]    rx_data,
	input  wire logic          rx_frame_err,
	input  wire logic          baud_tick,
	input  wire logic          rx_pin,
	input  wire logic          break_done,
	// status out
	output logic      [LW-1:0] rx_level,
	output logic      [LW-1:0] tx_level,
	output logic               uart_irq,
	output logic      [2:0]    hdr_state
);
	// ********************************************************************
	// declarations
	// ********************************************************************
	logic [7:0] en_q;
	logic       rx_overflow_flag_q;
	logic       rx_underflow_flag_q;
	logic       tx_overflow_flag_q;
	logic       frame_error_flag_q;
	logic       tx_done_flag_q;
	logic       rx_avail_flag_q;
	logic       idle_avail_q;
	logic [15:0] idle_cnt_q;
	logic       rx_s1_q;
	logic       rx_s2_q;
	logic       rx_s3_q;
	logic       tx_busy_q;
	logic       tx_space_flag;
	logic       wr_irq;
	logic       wr_data;
	logic       rd_data;
	logic       rxq_valid;
	logic [7:0] rxq_data;
	logic       txq_ready;
	logic [LW-1:0] rx_lvl;
	logic [LW-1:0] tx_lvl;
	logic [7:0] status;
	logic       rd_lvl_ok;
	esu_hdr_t   hdr_q;

	// single place that decodes a bus strobe against an address
	function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] want);
		hit = strobe && (a == want);
	endfunction

	assign wr_irq  = hit(sfr_wr, sfr_addr, `ESU_ADDR_IRQ);
	assign wr_data = hit(sfr_wr, sfr_addr, `ESU_ADDR_DATA);
	assign rd_data = hit(sfr_rd, sfr_addr, `ESU_ADDR_DATA);

	// ********************************************************************
	// queues
	// ********************************************************************
	// transmit queue: bus writes fill it, the shifter drains it
	esu_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(LW)) u_txq (
		.clk       (clk),
		.rst       (rst),
		.flush     (port_disable),
		.in_valid  (wr_data),
		.in_ready  (txq_ready),
		.in_data   (sfr_wdata),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data),
		.level     (tx_lvl)
	);

	// receive queue: shifter fills it, a data-port read pops it; full stalls the shifter
	esu_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(LW)) u_rxq (
		.clk       (clk),
		.rst       (rst),
		.flush     (port_disable),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   (rx_data),
		.out_valid (rxq_valid),
		.out_ready (rd_data),
		.out_data  (rxq_data),
		.level     (rx_lvl)
	);

	assign rx_level = rx_lvl;
	assign tx_level = tx_lvl;

	// ********************************************************************
	// event flags
	// ********************************************************************
	// level flag, no storage: follows the queue directly
	assign tx_space_flag = (tx_lvl < tx_threshold);
	assign rd_lvl_ok     = (rx_lvl >= rx_threshold) && (rx_threshold != '0);

	// enables: one written, zero written clears; bit 7 is the master gate
	always_ff @(posedge clk) begin
		if (rst) begin
			en_q <= `ESU_RST_IRQ;
		end else if (wr_irq) begin
			en_q <= sfr_wdata;
		end
	end

	// error flags: set beats a clearing write; queue reset clears overflow and underflow
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_overflow_flag_q  <= 1'b0;
			rx_underflow_flag_q <= 1'b0;
			tx_overflow_flag_q  <= 1'b0;
			frame_error_flag_q  <= 1'b0;
		end else begin
			if (rx_valid && !rx_ready) begin
				rx_overflow_flag_q <= 1'b1;
			end else if (port_disable) begin
				rx_overflow_flag_q <= 1'b0;
			end else if (wr_irq && !sfr_wdata[`ESU_BIT_RXOVF]) begin
				rx_overflow_flag_q <= 1'b0;
			end
			if (rd_data && !rxq_valid) begin
				rx_underflow_flag_q <= 1'b1;
			end else if (port_disable) begin
				rx_underflow_flag_q <= 1'b0;
			end else if (wr_irq && !sfr_wdata[`ESU_BIT_RXUDF]) begin
				rx_underflow_flag_q <= 1'b0;
			end
			if (wr_data && !txq_ready) begin
				tx_overflow_flag_q <= 1'b1;
			end else if (port_disable) begin
				tx_overflow_flag_q <= 1'b0;
			end else if (wr_irq && !sfr_wdata[`ESU_BIT_TXOVF]) begin
				tx_overflow_flag_q <= 1'b0;
			end
			if (rx_valid && rx_frame_err) begin
				frame_error_flag_q <= 1'b1;
			end else if (wr_irq && !sfr_wdata[`ESU_BIT_FRAME_ERROR_FLAG]) begin
				frame_error_flag_q <= 1'b0;
			end
		end
	end

	// transmit done: last bit shifted out with the queue empty, edge of the busy span
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_busy_q      <= 1'b0;
			tx_done_flag_q <= 1'b0;
		end else begin
			tx_busy_q <= tx_valid || !tx_shift_idle;
			if (tx_busy_q && !tx_valid && tx_shift_idle) begin
				tx_done_flag_q <= 1'b1;
			end else if (wr_irq && !sfr_wdata[`ESU_BIT_TXDONE]) begin
				tx_done_flag_q <= 1'b0;
			end
		end
	end

	// rx pin synchroniser; only the second and third stages are looked at
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
		end else begin
			rx_s1_q <= rx_pin;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
		end
	end

	// idle timer in baud periods; any line edge or a pop restarts it
	always_ff @(posedge clk) begin
		if (rst || port_disable || (rx_s2_q != rx_s3_q) || rd_data || rx_valid) begin
			idle_cnt_q   <= '0;
			idle_avail_q <= 1'b0;
		end else if (baud_tick && rxq_valid && (rx_lvl < rx_threshold)) begin
			if (idle_cnt_q > 16'(rx_threshold) * 16'(`ESU_IDLE_MULT)) begin
				idle_avail_q <= 1'b1;
			end else begin
				idle_cnt_q <= idle_cnt_q + 16'h0001;
			end
		end
	end

	// receive available: threshold reached or idle leftover; clears on zero write once drained
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_avail_flag_q <= 1'b0;
		end else if (rd_lvl_ok || idle_avail_q) begin
			rx_avail_flag_q <= 1'b1;
		end else if (wr_irq && !sfr_wdata[`ESU_BIT_RXAVAIL]) begin
			rx_avail_flag_q <= 1'b0;
		end
	end

	// ********************************************************************
	// read path and interrupt
	// ********************************************************************
	assign status = {en_q[`ESU_BIT_MASTER], tx_space_flag, rx_avail_flag_q, rx_overflow_flag_q,
			rx_underflow_flag_q, tx_overflow_flag_q, frame_error_flag_q, tx_done_flag_q};

	// read data registered; the data port shows the head byte as it is popped
	always_ff @(posedge clk) begin
		if (rst) begin
			sfr_rdata <= `ESU_RST_DATA;
		end else if (hit(sfr_rd, sfr_addr, `ESU_ADDR_IRQ)) begin
			sfr_rdata <= status;
		end else if (rd_data) begin
			sfr_rdata <= rxq_valid ? rxq_data : 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= 8'h00;
		end
	end

	// lin mode only adds sequencing; the plain uart path above is untouched by it
	assign uart_irq = en_q[`ESU_BIT_MASTER] && |(status[6:0] & en_q[6:0]);

	// ********************************************************************
	// lin master header tracker
	// ********************************************************************
	// follows break, sync, identifier, then data; checksum bytes are data to this view
	always_ff @(posedge clk) begin
		if (rst || !lin_enable) begin
			hdr_q <= ESU_HDR_IDLE;
		end else begin
			unique case (hdr_q)
				ESU_HDR_IDLE: begin
					if (lin_master && break_request) begin
						hdr_q <= ESU_HDR_BREAK;
					end
				end
				ESU_HDR_BREAK: begin
					if (break_done) begin
						hdr_q <= ESU_HDR_SYNC;
					end
				end
				ESU_HDR_SYNC: begin
					if (tx_valid && tx_ready) begin
						hdr_q <= ESU_HDR_ID;
					end
				end
				ESU_HDR_ID: begin
					if (tx_valid && tx_ready) begin
						hdr_q <= ESU_HDR_DATA;
					end
				end
				ESU_HDR_DATA: begin
					if (!tx_valid && tx_shift_idle) begin
						hdr_q <= ESU_HDR_IDLE;
					end
				end
			endcase
		end
	end

	assign hdr_state = hdr_q;
endmodule

/* bench/esu_core_sva.sv */
// concurrent checks on the ports of the serial interrupt/data block
`timescale 1ns/1ps
`include "esu_defs.svh"
module esu_core_sva
	import esu_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int LW    = 4
) (
	// clock and reset
	input wire logic          clk,
	input wire logic          rst,
	// special-function bus
	input wire logic [7:0]    sfr_addr,
	input wire logic          sfr_wr,
	input wire logic          sfr_rd,
	input wire logic [7:0]    sfr_wdata,
	input wire logic [7:0]    sfr_rdata,
	// configuration
	input wire logic          port_disable,
	input wire logic [LW-1:0] rx_threshold,
	input wire logic [LW-1:0] tx_threshold,
	// engine side
	input wire logic          tx_valid,
	input wire logic          tx_ready,
	input wire logic [7:0]    tx_data,
	input wire logic          rx_valid,
	input wire logic          rx_ready,
	// status
	input wire logic [LW-1:0] rx_level,
	input wire logic [LW-1:0] tx_level,
	input wire logic          uart_irq,
	input wire logic [2:0]    hdr_state
);
	logic men_q;
	logic rd_irq;
	logic rd_dat;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ************************************************
	// helper: mirror of the master enable as last written
	// ************************************************
	assign rd_irq = sfr_rd && sfr_addr == `ESU_ADDR_IRQ;
	assign rd_dat = sfr_rd && sfr_addr == `ESU_ADDR_DATA;
	always_ff @(posedge clk) begin
		if (rst)
			men_q <= 1'b0;
		else if (sfr_wr && sfr_addr == `ESU_ADDR_IRQ)
			men_q <= sfr_wdata[`ESU_BIT_MASTER];
	end

	AST_TXSPACE: assert property (rd_irq && tx_level == $past(tx_level) && tx_threshold == $past(tx_threshold)
		|=> sfr_rdata[6] == $past(tx_level < tx_threshold)) else $error("tx space flag wrong");
	AST_RXAVAIL: assert property (rd_irq && rx_threshold != 0 && rx_level >= rx_threshold
		&& $past(rx_level) >= rx_threshold |=> sfr_rdata[5]) else $error("rx avail flag missing");
	AST_RD_POP: assert property (rd_dat && rx_level != 0 && !rx_valid && !port_disable
		|=> rx_level == $past(rx_level) - 1'b1) else $error("data read did not pop");
	AST_RD_EMPTY: assert property (rd_dat && rx_level == 0 && !rx_valid |=> sfr_rdata == 8'h00)
		else $error("empty read not zero");
	AST_WR_PUSH: assert property (sfr_wr && sfr_addr == `ESU_ADDR_DATA && tx_level < DEPTH
		&& !(tx_valid && tx_ready) && !port_disable |=> tx_level == $past(tx_level) + 1'b1) else $error("no push");
	AST_FLUSH: assert property (port_disable |=> rx_level == 0 && tx_level == 0) else $error("flush failed");
	AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready && !port_disable |=> tx_valid && $stable(tx_data))
		else $error("tx offer dropped");
	AST_HDR_ORDER: assert property ($changed(hdr_state) |-> hdr_state == 3'h0
		|| hdr_state == $past(hdr_state) + 3'h1) else $error("header out of order");
	AST_IRQ_GATE: assert property (uart_irq |-> men_q) else $error("irq without master enable");

	// main scenarios seen
	cover property (sfr_wr && sfr_addr == `ESU_ADDR_DATA && tx_level == DEPTH);
	cover property (uart_irq);
	cover property (hdr_state == 3'h1);
endmodule

bind esu_core esu_core_sva #(.DEPTH(DEPTH), .LW(LW)) chk_u (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port_disable(port_disable),
	.rx_threshold(rx_threshold), .tx_threshold(tx_threshold), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_level(rx_level), .tx_level(tx_level),
	.uart_irq(uart_irq), .hdr_state(hdr_state));

/* bench/esu_line_model.sv */
// serial engine stand-in: drains transmit bytes slowly and feeds received bytes
`timescale 1ns/1ps
module esu_line_model (
	// clock
	input  wire logic       clk,
	// transmit drain
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	output logic            tx_shift_idle,
	// receive fill
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_frame_err,
	// line timing
	output logic            baud_tick,
	output wire logic       rx_pin
);
	logic [7:0] got[$];
	logic       stall = 1'b1;
	int         busy  = 0;
	int         tk    = 0;

	// line held idle high by a constant drive
	assign rx_pin = 1'b1;
	initial begin
		tx_ready = 1'b0;
		tx_shift_idle = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'hFF;
		rx_frame_err = 1'b0;
		baud_tick = 1'b0;
	end

	// one baud tick per 4 clocks; each byte keeps the shifter busy 10 clocks, so acceptance is slow
	always @(posedge clk) begin
		tk <= (tk == 3) ? 0 : tk + 1;
		baud_tick <= (tk == 3);
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			busy <= 10;
		end else if (busy != 0)
			busy <= busy - 1;
		tx_ready <= !stall && busy == 0 && !(tx_valid && tx_ready);
		tx_shift_idle <= busy == 0 && !(tx_valid && tx_ready);
	end

	// offer one received byte, hold it until taken, then scramble the released data; n reaches 400 on a stall
	task automatic send(input logic [7:0] b, input logic fe, output int n);
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_frame_err <= fe;
		n = 0;
		do @(negedge clk); while (!rx_ready && ++n < 400);
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		rx_frame_err <= 1'b0;
		// one idle edge, so back-to-back offers never rewrite the strobe within one time step
		@(posedge clk);
	endtask
endmodule

/* bench/esu_core_bench.sv */
// self-checking bench for the serial interrupt/data block
`timescale 1ns/1ps
`include "esu_defs.svh"
module esu_core_bench
	import esu_pkg::*;
;
	logic       clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, port_disable = 1'b0;
	logic       lin_enable = 1'b0, lin_master = 1'b0, break_request = 1'b0, break_done = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, tx_data, rx_data, d;
	logic [3:0] rx_threshold = 4'h2, tx_threshold = 4'h2, rx_level, tx_level;
	logic       tx_valid, tx_ready, tx_shift_idle, rx_valid, rx_ready, rx_frame_err, baud_tick, rx_pin, uart_irq;
	logic [2:0] hdr_state;
	int         n_mismatch = 0, checks_done = 0, i;

	always #12.5 clk = ~clk;

	esu_core #(.DEPTH(4), .LW(4)) dut_u (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port_disable(port_disable),
		.rx_threshold(rx_threshold), .tx_threshold(tx_threshold), .lin_enable(lin_enable), .lin_master(lin_master),
		.break_request(break_request), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_shift_idle(tx_shift_idle), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.rx_frame_err(rx_frame_err), .baud_tick(baud_tick), .rx_pin(rx_pin), .break_done(break_done),
		.rx_level(rx_level), .tx_level(tx_level), .uart_irq(uart_irq), .hdr_state(hdr_state));
	esu_line_model mdl_u (.clk(clk), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_shift_idle(tx_shift_idle), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.rx_frame_err(rx_frame_err), .baud_tick(baud_tick), .rx_pin(rx_pin));

	// ************************************************
	// bus tasks and result checking
	// ************************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		@(posedge clk);
	endtask
	// read data is registered and holds, so sampling one edge later is race free
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		v = sfr_rdata;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tmo(input int k);
		if (k >= 400) begin
			n_mismatch++;
			conclude();
		end
	endtask
	// receive offer through the line model; a refused offer counts as a timeout
	task automatic snd(input logic [7:0] b, input logic fe);
		int k;
		mdl_u.send(b, fe, k);
		tmo(k);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'h40);
		// master header with the drain stalled: break, sync, identifier, then data overfill
		cmp({4'h0, tx_level}, 8'h00);
		lin_enable <= 1'b1;
		lin_master <= 1'b1;
		break_request <= 1'b1;
		for (i = 0; i < 400 && hdr_state !== ESU_HDR_BREAK; i++) @(posedge clk);
		tmo(i); cmp({5'h0, hdr_state}, 8'h01);
		wr(`ESU_ADDR_DATA, `ESU_SYNC_BYTE);
		wr(`ESU_ADDR_DATA, 8'h1A);
		break_done <= 1'b1;
		@(posedge clk);
		break_done <= 1'b0;
		wr(`ESU_ADDR_DATA, 8'hB1);
		wr(`ESU_ADDR_DATA, 8'hB2);
		wr(`ESU_ADDR_DATA, 8'hB3);
		cmp({4'h0, tx_level}, 8'h04);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'h04);
		wr(`ESU_ADDR_IRQ, 8'h84); cmp({7'h0, uart_irq}, 8'h01);
		wr(`ESU_ADDR_IRQ, 8'h80); cmp({7'h0, uart_irq}, 8'h00);
		break_request <= 1'b0;
		mdl_u.stall <= 1'b0;
		for (i = 0; i < 400 && tx_level !== 4'h0; i++) @(posedge clk);
		tmo(i);
		repeat (20) @(posedge clk);
		cmp(8'(mdl_u.got.size()), 8'h04);
		cmp(mdl_u.got[0], 8'h55); cmp(mdl_u.got[1], 8'h1A); cmp(mdl_u.got[3], 8'hB2);
		cmp({5'h0, hdr_state}, 8'h00);
		lin_enable <= 1'b0;
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hC1);
		wr(`ESU_ADDR_IRQ, 8'h80);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hC0);
		// receive path: threshold, ordered pops, underflow, flush
		snd(8'hA1, 1'b0);
		snd(8'hA2, 1'b0);
		snd(8'hA3, 1'b0);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hE0);
		rd(`ESU_ADDR_DATA, d); cmp(d, 8'hA1);
		rd(`ESU_ADDR_DATA, d); cmp(d, 8'hA2);
		rd(`ESU_ADDR_DATA, d); cmp(d, 8'hA3);
		rd(`ESU_ADDR_DATA, d); cmp(d, 8'h00);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hE8);
		port_disable <= 1'b1;
		@(posedge clk);
		port_disable <= 1'b0;
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hE0);
		wr(`ESU_ADDR_IRQ, 8'h80);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hC0);
		// leftover byte below threshold reported only after the idle span
		snd(8'h3C, 1'b0);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hC0);
		repeat (200) @(posedge clk);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hE0);
		snd(8'h77, 1'b1);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hE2);
		port_disable <= 1'b1;
		@(posedge clk);
		port_disable <= 1'b0;
		wr(`ESU_ADDR_IRQ, 8'h80);
		rd(`ESU_ADDR_IRQ, d); cmp(d, 8'hC0);
		conclude();
	end
endmodule
